//--- rdc_mux.sv
// analog steering decode for the reference converter
// assumes control bits are already registered in the bus domain
`timescale 1ns/1ps
module rdc_mux (
    input wire logic [7:0] ctrl, // registered control byte
    output logic conv_on, // converter core enable
    output logic pin_drive, // analog output pin switch
    output logic route_pos, // low-power path uses positive source
    output logic [2:0] pos_sel, // one-hot positive source switch
    output logic neg_ext // negative reference is external
);
    import rdc_pkg::*;
    rdc_pss_t pss;

    // decode each switch from its bit, the positive source switches from the two-bit field
    always_comb begin
        pss = rdc_pss_t'(ctrl[RDC_BIT_PSS_HI:RDC_BIT_PSS_LO]);
        // R1 enable switch
        conv_on = ctrl[RDC_BIT_EN];
        // R3 pin switch
        pin_drive = ctrl[RDC_BIT_OE];
        // R2 low-power source
        route_pos = ctrl[RDC_BIT_LPS];
        // R6 negative source
        neg_ext = ctrl[RDC_BIT_NSS];
        // R4 positive source decode
        case (pss)
            RDC_PSS_SUPPLY: pos_sel = 3'h1;
            RDC_PSS_EXT: pos_sel = 3'h2;
            RDC_PSS_FVR: pos_sel = 3'h4;
            // R5 reserved code opens every positive source switch, a safe choice
            default: pos_sel = 3'h0;
        endcase
    end
endmodule

//--- rdc_pkg.sv
// package for the reference converter control block
// assumes a 32-bit axi4-lite slave port, 8-bit control register
package rdc_pkg;
    // register byte offsets
    localparam logic [3:0] RDC_OFF_CTRL = 4'h0; // control register
    localparam logic [3:0] RDC_OFF_RANGE = 4'h4; // range select register
    localparam logic [3:0] RDC_OFF_STAT = 4'h8; // sleep / status register
    // control field positions
    localparam int RDC_BIT_EN = 7; // converter enable
    localparam int RDC_BIT_LPS = 6; // low-power source select
    localparam int RDC_BIT_OE = 5; // analog pin drive enable
    localparam int RDC_BIT_PSS_HI = 3; // positive source field high
    localparam int RDC_BIT_PSS_LO = 2; // positive source field low
    localparam int RDC_BIT_NSS = 0; // negative source select
    // writable bit mask, bits 4 and 1 unimplemented
    localparam logic [7:0] RDC_CTRL_MASK = 8'hED;
    localparam logic [7:0] RDC_CTRL_RST = 8'h00; // control after reset
    localparam logic [4:0] RDC_RANGE_RST = 5'h00; // range after reset
    // axi responses
    localparam logic [1:0] RDC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RDC_RESP_SLVERR = 2'h2;
    // positive source codes
    typedef enum logic [1:0] {
        RDC_PSS_SUPPLY = 2'h0,
        RDC_PSS_EXT = 2'h1,
        RDC_PSS_FVR = 2'h2,
        RDC_PSS_RSVD = 2'h3
    } rdc_pss_t;
    // write channel states, one code each; RESP back to IDLE flips both bits
    typedef enum logic [1:0] {
        RDC_W_IDLE = 2'b00,
        RDC_W_HAVE_A = 2'b01,
        RDC_W_HAVE_D = 2'b10,
        RDC_W_RESP = 2'b11
    } rdc_wstate_t;
endpackage

//--- rdc_top.sv
// reference converter control block with axi4-lite register access
// assumes one clock, synchronous active-low reset, software-only control
// How it works
// R1 - bit 7 enables the converter
// R2 - bit 6 picks positive or negative source
// R3 - bit 5 drives converter onto output pin
// R4 - bits 3-2 choose positive reference source
// R5 - software never writes reserved source code
// R6 - bit 0 picks external negative or ground
// R7 - bits 4 and 1 read zero
// R8 - reset disables, removes output, clears range
// R9 - sleep and wake keep register contents
// R10 - software disables reference before sleep
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module rdc_top (
    input wire logic aclk, // 125 MHz clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic sleep_in, // device is asleep, level
    input wire logic [3:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [3:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic conv_on, // converter core enable
    output logic pin_drive, // analog output pin switch
    output logic route_pos, // low-power path positive source
    output logic [2:0] pos_sel, // one-hot positive source switch
    output logic neg_ext, // external negative reference
    output logic [4:0] range_sel // range select field
);
    import rdc_pkg::*;

    // register state
    logic [7:0] ctrl_ff, nxt_ctrl; // control register
    logic [4:0] range_ff, nxt_range; // range select register
    // write channel state
    rdc_wstate_t wst_ff, nxt_wst;
    logic [3:0] waddr_ff, nxt_waddr; // held write address
    logic [31:0] wdata_ff, nxt_wdata; // held write data
    logic [3:0] wstrb_ff, nxt_wstrb; // held strobes
    logic [1:0] bresp_ff, nxt_bresp; // write response code
    // read channel state
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic wr_do; // write commits this cycle

    // decode an offset into a known register
    function automatic logic is_mapped(input logic [3:0] a);
        is_mapped = (a == RDC_OFF_CTRL) || (a == RDC_OFF_RANGE) ||
            (a == RDC_OFF_STAT);
    endfunction

    // ready while waiting for that half of the write; a low clk_en hides
    // every ready so that no handshake is taken while the flops are frozen
    // limitation: a response must not be taken while clk_en is low
    assign s_axi_awready = clk_en && ((wst_ff == RDC_W_IDLE) ||
        (wst_ff == RDC_W_HAVE_D));
    assign s_axi_wready = clk_en && ((wst_ff == RDC_W_IDLE) ||
        (wst_ff == RDC_W_HAVE_A));
    assign s_axi_bvalid = (wst_ff == RDC_W_RESP);
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = clk_en && !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign range_sel = range_ff;

    // write channel: address and data in either order
    always_comb begin
        nxt_wst = wst_ff;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bresp = bresp_ff;
        wr_do = 1'b0;
        case (wst_ff)
            RDC_W_IDLE: begin
                if (s_axi_awvalid) begin
                    nxt_waddr = s_axi_awaddr;
                end
                if (s_axi_wvalid) begin
                    nxt_wdata = s_axi_wdata;
                    nxt_wstrb = s_axi_wstrb;
                end
                if (s_axi_awvalid && s_axi_wvalid) begin
                    nxt_wst = RDC_W_RESP;
                    wr_do = 1'b1;
                end else if (s_axi_awvalid) begin
                    nxt_wst = RDC_W_HAVE_A;
                end else if (s_axi_wvalid) begin
                    nxt_wst = RDC_W_HAVE_D;
                end
            end
            RDC_W_HAVE_A: begin
                if (s_axi_wvalid) begin
                    nxt_wdata = s_axi_wdata;
                    nxt_wstrb = s_axi_wstrb;
                    nxt_wst = RDC_W_RESP;
                    wr_do = 1'b1;
                end
            end
            RDC_W_HAVE_D: begin
                if (s_axi_awvalid) begin
                    nxt_waddr = s_axi_awaddr;
                    nxt_wst = RDC_W_RESP;
                    wr_do = 1'b1;
                end
            end
            RDC_W_RESP: begin
                if (s_axi_bready) begin
                    nxt_wst = RDC_W_IDLE;
                end
            end
            default: nxt_wst = RDC_W_IDLE;
        endcase
        if (wr_do) begin
            nxt_bresp = is_mapped(nxt_waddr) ? RDC_RESP_OKAY :
                RDC_RESP_SLVERR;
        end
    end

    // register update; only byte lane 0 carries data
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_range = range_ff;
        // R9 no sleep or wake term touches the registers
        if (wr_do && nxt_wstrb[0]) begin
            if (nxt_waddr == RDC_OFF_CTRL) begin
                // R7 unimplemented bits never store
                nxt_ctrl = nxt_wdata[7:0] & RDC_CTRL_MASK;
            end else if (nxt_waddr == RDC_OFF_RANGE) begin
                nxt_range = nxt_wdata[4:0];
            end
        end
    end

    // read channel, one cycle latency, held until rready
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (!rvalid_ff && s_axi_arvalid) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RDC_RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            case (s_axi_araddr)
                RDC_OFF_CTRL: nxt_rdata = {24'h00_0000, ctrl_ff};
                RDC_OFF_RANGE: nxt_rdata = {27'h000_0000, range_ff};
                // status shows sleep and a converter still powered
                RDC_OFF_STAT: nxt_rdata = {30'h0000_0000,
                    sleep_in & ctrl_ff[RDC_BIT_EN], sleep_in};
                default: nxt_rresp = RDC_RESP_SLVERR;
            endcase
        end
    end

    // registers, frozen while clk_en is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // R8 reset disables and clears range
            ctrl_ff <= RDC_CTRL_RST;
            range_ff <= RDC_RANGE_RST;
            wst_ff <= RDC_W_IDLE;
            waddr_ff <= 4'h0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bresp_ff <= RDC_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RDC_RESP_OKAY;
        end else if (clk_en) begin
            ctrl_ff <= nxt_ctrl;
            range_ff <= nxt_range;
            wst_ff <= nxt_wst;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // analog switch decode
    rdc_mux u_mux (
        .ctrl(ctrl_ff),
        .conv_on(conv_on),
        .pin_drive(pin_drive),
        .route_pos(route_pos),
        .pos_sel(pos_sel),
        .neg_ext(neg_ext)
    );

    // R1 enable follows bit 7
    AST_EN_FOLLOWS: assert property ( // R1
        @(posedge aclk) disable iff (!aresetn)
        conv_on == ctrl_ff[RDC_BIT_EN])
        else $error("enable mismatch");
    // R2 source select follows bit 6
    AST_LPS_FOLLOWS: assert property ( // R2
        @(posedge aclk) disable iff (!aresetn)
        route_pos == ctrl_ff[RDC_BIT_LPS])
        else $error("low-power source mismatch");
    // R3 pin drive follows bit 5
    AST_OE_FOLLOWS: assert property ( // R3
        @(posedge aclk) disable iff (!aresetn)
        pin_drive == ctrl_ff[RDC_BIT_OE])
        else $error("pin drive mismatch");
    // R4 supply code closes supply switch
    AST_PSS_SUPPLY: assert property ( // R4
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_ff[3:2] == 2'h0) |-> (pos_sel == 3'h1))
        else $error("supply decode wrong");
    // R4 external code closes external switch
    AST_PSS_EXT: assert property ( // R4
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_ff[3:2] == 2'h1) |-> (pos_sel == 3'h2))
        else $error("external decode wrong");
    // R4 buffer code closes buffer switch
    AST_PSS_DECODE: assert property ( // R4
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_ff[3:2] == 2'h2) |-> (pos_sel == 3'h4))
        else $error("buffer decode wrong");
    // R6 negative select follows bit 0
    AST_NSS_FOLLOWS: assert property ( // R6
        @(posedge aclk) disable iff (!aresetn)
        neg_ext == ctrl_ff[RDC_BIT_NSS])
        else $error("negative select mismatch");
    // R7 unimplemented bits stay zero
    AST_UNIMP_ZERO: assert property ( // R7
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_ff[4] == 1'b0) && (ctrl_ff[1] == 1'b0))
        else $error("unimplemented bit set");
    // R7 control reads zero in its gaps
    AST_READ_UNIMP: assert property ( // R7
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == RDC_OFF_CTRL) |=>
        ((s_axi_rdata[31:8] == 24'h00_0000) &&
        !s_axi_rdata[4] && !s_axi_rdata[1]))
        else $error("unimplemented bit read back");
    // R8 after reset enable, pin drive and range cleared
    AST_RESET_CLEAR: assert property ( // R8
        @(posedge aclk)
        !aresetn |=> (!conv_on && !pin_drive && range_sel == 5'h00))
        else $error("reset did not clear");
    // R8 reset leaves registers at rest values
    AST_RESET_REGS: assert property ( // R8
        @(posedge aclk) !aresetn |=> (ctrl_ff == RDC_CTRL_RST &&
        range_ff == RDC_RANGE_RST && pos_sel == 3'h1))
        else $error("reset left a register set");
    // R9 control changes only by a committed write
    AST_HOLD_NO_WRITE: assert property ( // R9
        @(posedge aclk) disable iff (!aresetn)
        (!wr_do || !clk_en) |=> $stable(ctrl_ff))
        else $error("control changed without write");
    // R9 sleep edges leave control alone
    AST_SLEEP_HOLD: assert property ( // R9
        @(posedge aclk) disable iff (!aresetn)
        ($changed(sleep_in) && !wr_do) |=> $stable(ctrl_ff))
        else $error("sleep change moved control");
    // range changes only by a committed write
    AST_RANGE_HOLD: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!wr_do || !clk_en) |=> $stable(range_ff))
        else $error("range changed without write");
    // frozen clock enable holds both registers
    AST_FREEZE_HOLD: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !clk_en |=> ($stable(ctrl_ff) && $stable(range_ff)))
        else $error("state moved while frozen");
    // frozen bus offers no ready
    AST_FROZEN_READY: assert property (
        @(posedge aclk)
        !clk_en |-> (!s_axi_awready && !s_axi_wready && !s_axi_arready))
        else $error("ready shown while frozen");
    // write response comes one cycle after the write commits
    AST_BVALID_AFTER: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_do && clk_en) |=> s_axi_bvalid)
        else $error("bvalid missing");
    // read answer comes one cycle after the address is taken
    AST_RVALID_AFTER: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("rvalid missing");
endmodule

//--- rdc_top_test.sv
// self-checking bench for the reference converter control block
// assumes the axi4-lite slave answers within a few cycles of each request
`timescale 1ns/1ps
module rdc_top_test;
    import rdc_pkg::*;
    logic aclk, aresetn, clk_en, sleep_in; // clock, reset, freeze, sleep
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr; // addresses, strobes
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready; // write handshakes
    logic s_axi_arvalid, s_axi_rready; // read handshakes
    logic s_axi_awready, s_axi_wready, s_axi_bvalid; // slave write side
    logic s_axi_arready, s_axi_rvalid; // slave read side
    logic [31:0] s_axi_wdata, s_axi_rdata; // data buses
    logic [1:0] s_axi_bresp, s_axi_rresp; // responses
    logic conv_on, pin_drive, route_pos, neg_ext; // analog controls
    logic [2:0] pos_sel; // positive source switch
    logic [4:0] range_sel; // range field
    int error_cnt, comparisons; // verdict counters
    logic [31:0] v; // random draw
    logic [1:0] r; // response seen
    rdc_top rdc_top_i (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .sleep_in(sleep_in), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .conv_on(conv_on), .pin_drive(pin_drive), .route_pos(route_pos),
        .pos_sel(pos_sel), .neg_ext(neg_ext), .range_sel(range_sel));
    // 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // single place that ends the run
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one compare for data, output and range values, zero-extended to a word
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // compare for bus response codes
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // expected analog controls from a control byte
    function automatic logic [31:0] exp_outs(input logic [7:0] c);
        logic [2:0] p;
        case (c[3:2])
            2'h0: p = 3'h1;
            2'h1: p = 3'h2;
            2'h2: p = 3'h4;
            default: p = 3'h0;
        endcase
        return {25'h0, c[7], c[5], c[6], p, c[0]};
    endfunction
    // analog outputs packed like exp_outs
    function automatic logic [31:0] outs();
        return {25'h0, conv_on, pin_drive, route_pos, pos_sel, neg_ext};
    endfunction
    // a bound hit means the slave hung: count it and stop
    task automatic bound(input int n);
        if (n >= 50) begin
            error_cnt++;
            print_verdict();
        end
    endtask
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] er);
        int n;
        logic aw, w;
        n = 0;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (aw && s_axi_awready === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while ((aw || w) && n < 50);
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        bound(n);
        cmp_resp(s_axi_bresp, er);
    endtask
    // read and compare data and response
    task automatic rd(input logic [3:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 50);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        bound(n);
        cmp(s_axi_rdata, ed);
        cmp_resp(s_axi_rresp, er);
    endtask
    // synchronous reset held for three edges
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // main sequence
    initial begin
        error_cnt = 0;
        comparisons = 0;
        clk_en <= 1'b1;
        sleep_in <= 1'b0;
        s_axi_awaddr <= 4'h0;
        s_axi_awvalid <= 1'b0;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'h0;
        s_axi_wvalid <= 1'b0;
        // response readies stay high: every answer is taken at once
        s_axi_bready <= 1'b1;
        s_axi_araddr <= 4'h0;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        v = $urandom(37367);
        do_reset();
        cmp(outs(), exp_outs(8'h00));
        rd(RDC_OFF_CTRL, 32'h0, RDC_RESP_OKAY);
        rd(RDC_OFF_RANGE, 32'h0, RDC_RESP_OKAY);
        // random control bytes; each allowed source code in turn
        for (int i = 0; i < 13; i++) begin
            v = (i == 12) ? 32'hF3 : ($urandom & 32'hF3);
            v[3:2] = 2'(i % 3);
            wr(RDC_OFF_CTRL, v, 4'hF, RDC_RESP_OKAY);
            cmp(outs(), exp_outs(v[7:0]));
            rd(RDC_OFF_CTRL, v & 32'hED, RDC_RESP_OKAY);
            v = $urandom & 32'h1F;
            wr(RDC_OFF_RANGE, v, 4'hF, RDC_RESP_OKAY);
            cmp({27'h000_0000, range_sel}, v);
        end
        // strobe low leaves control alone; unmapped place refused
        wr(RDC_OFF_CTRL, 32'hA5, 4'hF, RDC_RESP_OKAY);
        wr(RDC_OFF_CTRL, 32'h00, 4'hE, RDC_RESP_OKAY);
        wr(4'hC, 32'h00, 4'hF, RDC_RESP_SLVERR);
        rd(4'hC, 32'h0, RDC_RESP_SLVERR);
        // sleep and wake keep the control byte
        sleep_in <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(RDC_OFF_STAT, 32'h3, RDC_RESP_OKAY);
        sleep_in <= 1'b0;
        @(posedge aclk);
        rd(RDC_OFF_CTRL, 32'hA5, RDC_RESP_OKAY);
        cmp(outs(), exp_outs(8'hA5));
        // a low clock enable holds an offered write off until it returns
        clk_en <= 1'b0;
        fork
            wr(RDC_OFF_CTRL, 32'h49, 4'hF, RDC_RESP_OKAY);
            begin
                repeat (5) @(posedge aclk);
                cmp(outs(), exp_outs(8'hA5));
                clk_en <= 1'b1;
            end
        join
        cmp(outs(), exp_outs(8'h49));
        // reset in mid-run clears enable, pin drive and range
        wr(RDC_OFF_RANGE, 32'h1F, 4'hF, RDC_RESP_OKAY);
        do_reset();
        cmp(outs(), exp_outs(8'h00));
        cmp({27'h000_0000, range_sel}, 32'h0);
        print_verdict();
    end
endmodule
